/* inc/fle_pkg.sv */
// Package for the fault log entry encoder: codes, snapshot layout, types
package fle_pkg;
    // Error categories and numbers
    localparam logic [7:0] FLE_CAT_FEEDBACK = 8'h17;    // 23
    localparam logic [7:0] FLE_CAT_CARD = 8'h18;        // 24
    localparam logic [7:0] FLE_CAT_SUPPLY = 8'h1a;      // 26
    localparam logic [7:0] FLE_CAT_TEMP = 8'h1b;        // 27
    localparam logic [7:0] FLE_NUM_TON = 8'h02;
    localparam logic [7:0] FLE_NUM_TOFF = 8'h03;
    localparam logic [7:0] FLE_NUM_ZERO = 8'h00;
    localparam logic [7:0] FLE_NUM_ONTEST = 8'h01;
    // Parameter 2 codes for release-time faults
    localparam logic [31:0] FLE_TON_AT_EXPIRY = 32'h0000_0001;
    localparam logic [31:0] FLE_TON_AFTER = 32'h0000_0002;
    // Parameter 2 codes for application-time faults
    localparam logic [31:0] FLE_TOFF_FAST = 32'h0000_0001;
    localparam logic [31:0] FLE_TOFF_SLOW = 32'h0000_0002;
    localparam logic [31:0] FLE_TOFF_FAST_EARLY = 32'h0000_0003;
    localparam logic [31:0] FLE_TOFF_SLOW_EARLY = 32'h0000_0004;
    localparam logic [31:0] FLE_TOFF_FAST_LATE = 32'h0000_0005;
    // Snapshot digit layout
    localparam int FLE_DIGIT_W = 4;
    localparam int FLE_SNAP_W = 32;
    localparam int FLE_D_SUPPLY = 0;
    localparam int FLE_D_CH1_IN = 1;
    localparam int FLE_D_CH2_IN = 2;
    localparam int FLE_D_OUTS = 4;
    localparam int FLE_D_CH1_OUT = 5;
    localparam int FLE_D_CH2_OUT = 6;
    localparam logic [31:0] FLE_SNAP_RST = 32'h0000_0000;
    localparam int FLE_NUM_SRC = 8;

    typedef enum logic [1:0] {FLE_LOC_NONE, FLE_LOC_CH1, FLE_LOC_CH2} fle_loc_e;

    // Terminal levels sampled for the snapshot
    typedef struct packed {
        logic device_supply_terminals;
        logic circuit_supply_terminals;
        logic fast_off_in_a_ch1;
        logic fast_off_in_b_ch1;
        logic slow_off_in_ch1;
        logic feedback_in_ch1;
        logic fast_off_in_a_ch2;
        logic fast_off_in_b_ch2;
        logic slow_off_in_ch2;
        logic feedback_in_ch2;
        logic fault_signal_out;
        logic test_pulse_out_zero;
        logic test_pulse_out_one;
        logic power_high_side_ch1;
        logic power_low_side_ch1;
        logic status_out_ch1;
        logic power_high_side_ch2;
        logic power_low_side_ch2;
        logic status_out_ch2;
    } fle_io_s;

    // Fault events, one-cycle pulses from the supervising logic
    typedef struct packed {
        logic ton_at_expiry;
        logic ton_after;
        logic [2:0] toff_kind;   // 1..5 as parameter 2, 0 = none
        logic card_unreadable;
        logic supply_after_on;
        logic supply_after_test;
        logic over_temp;
        fle_loc_e loc;
    } fle_evt_s;

    // One logged entry
    typedef struct packed {
        logic [7:0] category;
        logic [7:0] number;
        fle_loc_e loc;
        logic [31:0] param2;
        logic [31:0] snapshot;
    } fle_entry_s;
endpackage : fle_pkg

/* rtl/fle_snap_enc.sv */
// Packs terminal levels into the registered 32-bit I/O status word
`timescale 1ns/1ps
module fle_snap_enc (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic capture,
    input fle_pkg::fle_io_s io,
    output logic [31:0] snap
);
    import fle_pkg::*;

    typedef struct packed {
        logic [31:0] snap;
    } fle_snap_st_s;

    fle_snap_st_s st_r;
    fle_snap_st_s st_nxt;

    function automatic logic [3:0] fle_digit(input logic b0, input logic b1,
                                             input logic b2, input logic b3);
        fle_digit = {b3, b2, b1, b0};
    endfunction : fle_digit

    // Word built combinationally; digit 0 least significant
    always_comb begin
        logic [31:0] w;
        w = FLE_SNAP_RST;   // Digits 3, 7 and reserved weights stay zero
        w[FLE_D_SUPPLY*FLE_DIGIT_W +: FLE_DIGIT_W] = fle_digit(io.device_supply_terminals,
            io.circuit_supply_terminals, 1'b0, 1'b0);
        w[FLE_D_CH1_IN*FLE_DIGIT_W +: FLE_DIGIT_W] = fle_digit(io.fast_off_in_a_ch1,
            io.fast_off_in_b_ch1, io.slow_off_in_ch1, io.feedback_in_ch1);
        w[FLE_D_CH2_IN*FLE_DIGIT_W +: FLE_DIGIT_W] = fle_digit(io.fast_off_in_a_ch2,
            io.fast_off_in_b_ch2, io.slow_off_in_ch2, io.feedback_in_ch2);
        w[FLE_D_OUTS*FLE_DIGIT_W +: FLE_DIGIT_W] = fle_digit(io.fault_signal_out,
            io.test_pulse_out_zero, io.test_pulse_out_one, 1'b0);
        w[FLE_D_CH1_OUT*FLE_DIGIT_W +: FLE_DIGIT_W] = fle_digit(io.power_high_side_ch1,
            io.power_low_side_ch1, io.status_out_ch1, 1'b0);
        w[FLE_D_CH2_OUT*FLE_DIGIT_W +: FLE_DIGIT_W] = fle_digit(io.power_high_side_ch2,
            io.power_low_side_ch2, io.status_out_ch2, 1'b0);
        st_nxt = st_r;
        if (capture) begin
            st_nxt.snap = w;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign snap = st_r.snap;

    // Reserved places stay zero; digits follow the terminals seen on capture
    a_snap_reserved: assert property (@(posedge core_clk) disable iff (!nrst)
        (snap[15:12] == 4'h0) && (snap[31:28] == 4'h0) && (snap[3:2] == 2'h0)
        && (snap[19] == 1'h0) && (snap[23] == 1'h0) && (snap[27] == 1'h0))
        else $error("reserved snapshot bit set");
    a_snap_ch1_in: assert property (@(posedge core_clk) disable iff (!nrst)
        capture |=> snap[7:4] == {$past(io.feedback_in_ch1), $past(io.slow_off_in_ch1),
        $past(io.fast_off_in_b_ch1), $past(io.fast_off_in_a_ch1)})
        else $error("channel 1 input digit wrong");
    a_snap_outs: assert property (@(posedge core_clk) disable iff (!nrst)
        capture |=> snap[18:16] == {$past(io.test_pulse_out_one),
        $past(io.test_pulse_out_zero), $past(io.fault_signal_out)})
        else $error("output digit wrong");
endmodule : fle_snap_enc

/* rtl/fle_fault_log.sv */
// Fault log entry encoder: turns fault events into category/number entries
`timescale 1ns/1ps
// How it works
// - Release-time feedback fault logs 23/2, param 1/2
// - Application-time feedback fault logs 23/3, param 1..5
// - Unreadable configuration card logs 24/0
// - Circuit supply bad after switch-on logs 26/0
// - Circuit supply bad after on-test logs 26/1
// - Over-temperature indication logs 27/0
// - Entries carry an I/O snapshot at fault
// - Snapshot is eight 4-bit hex digits
// - Digit 0: device supply 1, circuit supply 2
// - Digit 1: channel 1 inputs, weights 1,2,4,8
// - Digit 2: channel 2 inputs, same weights
// - Digit 4: fault signal, test pulses 0,1
// - Digit 5: channel 1 high, low, status
// - Digit 6: channel 2 high, low, status
module fle_fault_log (
    input wire logic core_clk,
    input wire logic nrst,
    input fle_pkg::fle_evt_s evt,
    input fle_pkg::fle_io_s io,
    input wire logic entry_ack,
    output logic entry_valid,
    output fle_pkg::fle_entry_s entry,
    output logic overflow
);
    import fle_pkg::*;

    // Block state but the snapshot, which u_snap holds; one register, filled by one combinational process
    typedef struct packed {
        logic valid;
        logic pend;       // Entry goes valid next cycle
        logic overflow;
        logic [7:0] category;
        logic [7:0] number;
        fle_loc_e loc;
        logic [31:0] param2;
    } fle_st_s;

    fle_st_s st_r;
    fle_st_s st_nxt;
    logic any_evt;
    logic capture;
    logic [31:0] snap;

    // Sample terminals on the fault cycle itself
    fle_snap_enc u_snap (
        .core_clk(core_clk),
        .nrst(nrst),
        .capture(capture),
        .io(io),
        .snap(snap)
    );

    // Any set flag or nonzero toff_kind counts as a fault, loc does not; which one wins is sorted out below
    assign any_evt = evt.ton_at_expiry | evt.ton_after | (evt.toff_kind != 3'd0)
        | evt.card_unreadable | evt.supply_after_on | evt.supply_after_test
        | evt.over_temp;
    // Only one entry held; a busy holder keeps the first fault, later ones count as lost
    assign capture = any_evt && !st_r.valid && !st_r.pend;

    // Fixed priority: feedback, card, supply, temperature
    always_comb begin
        st_nxt = st_r;
        if (st_r.pend) begin
            st_nxt.pend = 1'b0;
            st_nxt.valid = 1'b1;
        end else if (st_r.valid && entry_ack) begin
            st_nxt.valid = 1'b0;
        end
        // A second fault while busy is lost; the sticky flag tells software
        if (any_evt && (st_r.valid || st_r.pend)) begin
            st_nxt.overflow = 1'b1;
        end
        if (capture) begin
            st_nxt.pend = 1'b1;
            st_nxt.loc = evt.loc;
            st_nxt.param2 = 32'h0000_0000;
            st_nxt.number = FLE_NUM_ZERO;
            if (evt.ton_at_expiry || evt.ton_after) begin
                st_nxt.category = FLE_CAT_FEEDBACK;
                st_nxt.number = FLE_NUM_TON;
                st_nxt.param2 = evt.ton_at_expiry ? FLE_TON_AT_EXPIRY : FLE_TON_AFTER;
            end else if (evt.toff_kind != 3'd0) begin
                st_nxt.category = FLE_CAT_FEEDBACK;
                st_nxt.number = FLE_NUM_TOFF;
                case (evt.toff_kind)
                    3'd1: st_nxt.param2 = FLE_TOFF_FAST;
                    3'd2: st_nxt.param2 = FLE_TOFF_SLOW;
                    3'd3: st_nxt.param2 = FLE_TOFF_FAST_EARLY;
                    3'd4: st_nxt.param2 = FLE_TOFF_SLOW_EARLY;
                    default: st_nxt.param2 = FLE_TOFF_FAST_LATE;
                endcase
            end else if (evt.card_unreadable) begin
                st_nxt.category = FLE_CAT_CARD;
                st_nxt.loc = FLE_LOC_NONE;
            end else if (evt.supply_after_on) begin
                st_nxt.category = FLE_CAT_SUPPLY;
            end else if (evt.supply_after_test) begin
                st_nxt.category = FLE_CAT_SUPPLY;
                st_nxt.number = FLE_NUM_ONTEST;
            end else begin
                st_nxt.category = FLE_CAT_TEMP;
                st_nxt.loc = FLE_LOC_NONE;
            end
        end
    end

    // One register for all state but the snapshot, cleared by reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Entry fields all from flip-flops; one driver for the whole entry
    assign entry_valid = st_r.valid;
    assign overflow = st_r.overflow;
    assign entry = '{category: st_r.category, number: st_r.number, loc: st_r.loc,
        param2: st_r.param2, snapshot: snap};

    // Entry contents, checked two edges after the taking edge
    a_ton_entry: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && evt.ton_at_expiry) |-> ##2 entry_valid
        && entry.category == FLE_CAT_FEEDBACK && entry.number == FLE_NUM_TON
        && entry.param2 == FLE_TON_AT_EXPIRY)
        else $error("release-time entry wrong");
    a_ton_late: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && !evt.ton_at_expiry && evt.ton_after) |-> ##2 entry_valid
        && entry.category == FLE_CAT_FEEDBACK && entry.number == FLE_NUM_TON
        && entry.param2 == FLE_TON_AFTER)
        else $error("late release-time entry wrong");
    a_toff_entry: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && !evt.ton_at_expiry && !evt.ton_after && evt.toff_kind == 3'h5)
        |-> ##2 entry.number == FLE_NUM_TOFF && entry.param2 == FLE_TOFF_FAST_LATE)
        else $error("application-time entry wrong");
    a_toff_code: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && !evt.ton_at_expiry && !evt.ton_after && evt.toff_kind != 3'h0
        && evt.toff_kind <= 3'h5) |-> ##2 entry.category == FLE_CAT_FEEDBACK
        && entry.param2 == {29'h0000_0000, $past(evt.toff_kind, 2)})
        else $error("application-time code wrong");
    a_card_entry: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && evt.card_unreadable && !evt.ton_at_expiry && !evt.ton_after
        && evt.toff_kind == 3'h0) |-> ##2 entry.category == FLE_CAT_CARD
        && entry.number == FLE_NUM_ZERO && entry.loc == FLE_LOC_NONE)
        else $error("card entry wrong");
    a_supply_on: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && evt.supply_after_on && !evt.card_unreadable && !evt.ton_at_expiry
        && !evt.ton_after && evt.toff_kind == 3'h0) |-> ##2
        entry.category == FLE_CAT_SUPPLY && entry.number == FLE_NUM_ZERO
        && entry.loc == $past(evt.loc, 2))
        else $error("supply switch-on entry wrong");
    a_supply_test: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && evt.supply_after_test && !evt.supply_after_on && !evt.card_unreadable
        && !evt.ton_at_expiry && !evt.ton_after && evt.toff_kind == 3'h0) |-> ##2
        entry.category == FLE_CAT_SUPPLY && entry.number == FLE_NUM_ONTEST
        && entry.loc == $past(evt.loc, 2))
        else $error("supply on-test entry wrong");
    a_temp_entry: assert property (@(posedge core_clk) disable iff (!nrst)
        (capture && evt.over_temp && !evt.ton_at_expiry && !evt.ton_after
        && evt.toff_kind == 3'h0 && !evt.card_unreadable && !evt.supply_after_on
        && !evt.supply_after_test) |-> ##2 entry.category == FLE_CAT_TEMP
        && entry.number == FLE_NUM_ZERO && entry.loc == FLE_LOC_NONE)
        else $error("temperature entry wrong");

    // Snapshot attached to the entry is the one taken on the fault cycle
    a_snap_taken: assert property (@(posedge core_clk) disable iff (!nrst)
        capture |-> ##2 entry_valid && entry.snapshot[1:0] ==
        {$past(io.circuit_supply_terminals, 2), $past(io.device_supply_terminals, 2)})
        else $error("snapshot not attached");
    a_snap_ch2_in: assert property (@(posedge core_clk) disable iff (!nrst)
        capture |-> ##2 entry.snapshot[11:8] == {$past(io.feedback_in_ch2, 2),
        $past(io.slow_off_in_ch2, 2), $past(io.fast_off_in_b_ch2, 2),
        $past(io.fast_off_in_a_ch2, 2)})
        else $error("channel 2 input digit wrong");
    a_snap_ch1_out: assert property (@(posedge core_clk) disable iff (!nrst)
        capture |-> ##2 entry.snapshot[23:20] == {1'h0, $past(io.status_out_ch1, 2),
        $past(io.power_low_side_ch1, 2), $past(io.power_high_side_ch1, 2)})
        else $error("channel 1 output digit wrong");
    a_snap_ch2: assert property (@(posedge core_clk) disable iff (!nrst)
        capture |-> ##2 entry.snapshot[27:24] == {1'h0, $past(io.status_out_ch2, 2),
        $past(io.power_low_side_ch2, 2), $past(io.power_high_side_ch2, 2)})
        else $error("channel 2 output digit wrong");
    a_snap_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        entry_valid |-> entry.snapshot[15:12] == 4'h0 && entry.snapshot[31:28] == 4'h0)
        else $error("unused snapshot digit set");

    // Holder handshake and the lost-event flag
    a_pend_once: assert property (@(posedge core_clk) disable iff (!nrst)
        st_r.pend |=> !st_r.pend && entry_valid)
        else $error("pending entry not raised");
    a_idle_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        (!entry_valid && !st_r.pend && !capture) |=> !entry_valid)
        else $error("entry raised without a fault");
    a_entry_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        (entry_valid && !entry_ack) |=> entry_valid && $stable(entry))
        else $error("held entry changed before ack");
    a_ack_clears: assert property (@(posedge core_clk) disable iff (!nrst)
        (entry_valid && entry_ack) |=> !entry_valid)
        else $error("acked entry still valid");
    a_ovf_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (any_evt && (entry_valid || st_r.pend)) |=> overflow)
        else $error("lost event not flagged");
    a_ovf_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        (!overflow && !(any_evt && (entry_valid || st_r.pend))) |=> !overflow)
        else $error("overflow flag set without a lost event");
    a_ovf_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
        overflow |=> overflow)
        else $error("overflow flag dropped");

    // Main scenarios
    c_ton: cover property (@(posedge core_clk) disable iff (!nrst) capture && evt.ton_after);
    c_toff: cover property (@(posedge core_clk) disable iff (!nrst)
        capture && evt.toff_kind == 3'h3);
    c_ovf: cover property (@(posedge core_clk) disable iff (!nrst) any_evt && entry_valid);
    c_ack: cover property (@(posedge core_clk) disable iff (!nrst) entry_valid && entry_ack);
    c_temp: cover property (@(posedge core_clk) disable iff (!nrst) capture && evt.over_temp);
endmodule : fle_fault_log

/* sim/fle_fault_log_tb.sv */
// Self-checking bench for the fault log entry encoder
`timescale 1ns/1ps
module fle_fault_log_tb;
    import fle_pkg::*;
    typedef struct packed {
        fle_evt_s ev;
        fle_io_s io;
        fle_entry_s exp;
    } fle_row_s;
    logic core_clk;
    logic nrst;
    fle_evt_s evt;
    fle_io_s io;
    logic entry_ack;
    logic entry_valid;
    fle_entry_s entry;
    logic overflow;
    int n_errors;
    int num_checks;
    fle_row_s rows[$];
    fle_row_s r0;

    fle_fault_log uut (.core_clk(core_clk), .nrst(nrst), .evt(evt), .io(io),
        .entry_ack(entry_ack), .entry_valid(entry_valid), .entry(entry), .overflow(overflow));

    // Expected snapshot built bit by bit from the terminal levels
    function automatic logic [31:0] snap_of(input fle_io_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[1:0] = {s.circuit_supply_terminals, s.device_supply_terminals};
        w[7:4] = {s.feedback_in_ch1, s.slow_off_in_ch1, s.fast_off_in_b_ch1,
            s.fast_off_in_a_ch1};
        w[11:8] = {s.feedback_in_ch2, s.slow_off_in_ch2, s.fast_off_in_b_ch2,
            s.fast_off_in_a_ch2};
        w[18:16] = {s.test_pulse_out_one, s.test_pulse_out_zero, s.fault_signal_out};
        w[22:20] = {s.status_out_ch1, s.power_low_side_ch1, s.power_high_side_ch1};
        w[26:24] = {s.status_out_ch2, s.power_low_side_ch2, s.power_high_side_ch2};
        return w; // Digits 3, 7 and reserved weights left at zero
    endfunction : snap_of

    // Flags: expiry, after, kind[2:0], card, on, test, temp
    function automatic fle_evt_s mkev(input logic [8:0] f, input fle_loc_e l);
        return fle_evt_s'({f, l});
    endfunction : mkev

    task automatic add(input fle_evt_s e, input logic [18:0] s, input logic [7:0] c,
        input logic [7:0] n, input fle_loc_e l, input logic [31:0] p);
        fle_row_s r;
        r.ev = e;
        r.io = fle_io_s'(s);
        r.exp = '{category: c, number: n, loc: l, param2: p, snapshot: snap_of(r.io)};
        rows.push_back(r);
    endtask : add

    task automatic chk_entry(input fle_entry_s got, input fle_entry_s exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_entry

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step

    // One event cycle; pending after the taking edge, valid after the next, then held
    task automatic send(input fle_row_s r);
        evt = r.ev;
        io = r.io;
        step();
        evt = '0;
        chk_bit(entry_valid, 1'b0);
        step();
        chk_bit(entry_valid, 1'b1);
        chk_entry(entry, r.exp);
        step();
        chk_bit(entry_valid, 1'b1);
        chk_entry(entry, r.exp);
    endtask : send

    task automatic take();
        entry_ack = 1'b1;
        step();
        entry_ack = 1'b0;
        chk_bit(entry_valid, 1'b0);
    endtask : take

    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Watchdog, far beyond the roughly 160 cycles the tests need
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        nrst = 1'b0;
        evt = '0;
        io = '0;
        entry_ack = 1'b0;
        n_errors = 0;
        num_checks = 0;
        add(mkev(9'h100, FLE_LOC_CH1), 19'h7ffff, FLE_CAT_FEEDBACK, FLE_NUM_TON, FLE_LOC_CH1,
            FLE_TON_AT_EXPIRY);
        add(mkev(9'h080, FLE_LOC_CH2), 19'h2aaaa, FLE_CAT_FEEDBACK, FLE_NUM_TON, FLE_LOC_CH2,
            FLE_TON_AFTER);
        for (int k = 1; k <= 5; k++) begin
            add(mkev({2'b00, 3'(k), 4'h0}, FLE_LOC_CH1), 19'h15555, FLE_CAT_FEEDBACK,
                FLE_NUM_TOFF, FLE_LOC_CH1, 32'(k));
        end
        add(mkev(9'h008, FLE_LOC_CH2), 19'h0f0f0, FLE_CAT_CARD, FLE_NUM_ZERO, FLE_LOC_NONE,
            32'h0);
        add(mkev(9'h004, FLE_LOC_CH1), 19'h40000, FLE_CAT_SUPPLY, FLE_NUM_ZERO, FLE_LOC_CH1,
            32'h0);
        add(mkev(9'h002, FLE_LOC_CH2), 19'h20000, FLE_CAT_SUPPLY, FLE_NUM_ONTEST, FLE_LOC_CH2,
            32'h0);
        // Several flags at once: highest priority wins
        add(mkev(9'h1ff, FLE_LOC_CH2), 19'h00000, FLE_CAT_FEEDBACK, FLE_NUM_TON, FLE_LOC_CH2,
            FLE_TON_AT_EXPIRY);
        add(mkev(9'h0ff, FLE_LOC_CH1), 19'h00000, FLE_CAT_FEEDBACK, FLE_NUM_TON, FLE_LOC_CH1,
            FLE_TON_AFTER);
        add(mkev(9'h03f, FLE_LOC_CH1), 19'h00000, FLE_CAT_FEEDBACK, FLE_NUM_TOFF, FLE_LOC_CH1,
            FLE_TOFF_FAST_EARLY);
        add(mkev(9'h00f, FLE_LOC_CH1), 19'h00000, FLE_CAT_CARD, FLE_NUM_ZERO, FLE_LOC_NONE,
            32'h0);
        add(mkev(9'h007, FLE_LOC_CH2), 19'h00000, FLE_CAT_SUPPLY, FLE_NUM_ZERO, FLE_LOC_CH2,
            32'h0);
        add(mkev(9'h003, FLE_LOC_CH1), 19'h00000, FLE_CAT_SUPPLY, FLE_NUM_ONTEST, FLE_LOC_CH1,
            32'h0);
        // Walking one over every terminal, so each snapshot bit is placed alone
        for (int b = 0; b < 19; b++) begin
            add(mkev(9'h001, FLE_LOC_NONE), 19'h00001 << b, FLE_CAT_TEMP, FLE_NUM_ZERO,
                FLE_LOC_NONE, 32'h0);
        end
        repeat (4) step();
        chk_bit(entry_valid, 1'b0);
        chk_bit(overflow, 1'b0);
        chk_entry(entry, '0);
        repeat (4) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        foreach (rows[i]) begin
            send(rows[i]);
            take();
        end
        // Event during a held entry is dropped and the first entry survives
        r0 = rows[0];
        send(r0);
        evt = mkev(9'h008, FLE_LOC_NONE);
        step();
        evt = '0;
        step();
        chk_bit(overflow, 1'b1);
        chk_entry(entry, r0.exp);
        take();
        repeat (3) step();
        chk_bit(entry_valid, 1'b0);
        chk_bit(overflow, 1'b1);
        // Reset in mid-run clears the sticky flag at once
        nrst = 1'b0;
        #2;
        chk_bit(overflow, 1'b0);
        chk_bit(entry_valid, 1'b0);
        step();
        nrst = 1'b1;
        send(rows[2]);
        take();
        complete_run();
    end
endmodule : fle_fault_log_tb
